/* core/ss_stop_seq.sv */
// Stop sequencer of a servo drive: picks and drives the stop profile.
// Assumes drive state machine transitions arrive as one-cycle pulses,
// speeds as signed synchronous words, and an AXI4-Lite master.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ss_stop_seq
  import ss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic enable_cmd,
  input wire logic qs_trans,
  input wire logic dis_trans,
  input wire logic sd_trans,
  input wire logic limit_sw,
  input wire logic inhibit_phys_input,
  input wire logic [31:0] ref_speed,
  input wire logic [31:0] motor_speed,
  output logic drive_en_r,
  output logic quick_stop_r,
  output logic stop_active_r,
  output ss_loop_t loop_sel_r,
  output logic [31:0] speed_sp_r,
  output logic cur_clamp_r,
  output logic [15:0] cur_limit_r
);

  // ==========================================================
  // Bus front end
  ss_wr_t wr;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;

  ss_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ==========================================================
  // Configuration registers
  logic [15:0] inh_sel_r;
  logic [31:0] slow_ramp_r;
  logic [15:0] clim_r;
  logic [15:0] tlim_r;
  logic [15:0] amp_r;
  logic [15:0] brk_r;
  logic [15:0] qs_sel_r;
  logic [15:0] sd_sel_r;
  logic [15:0] dis_sel_r;
  logic [31:0] qs_dec_r;
  ss_state_t state_r;
  ss_kind_t kind_r;
  logic hold_r;

  // Write decode; merged values prepared for the code checks
  wire logic [31:0] wr_mrg = ss_merge(32'h0000_0000, wr.data, wr.strb);
  wire logic w_inh = wr.en && wr.idx == SS_IDX_INH;
  wire logic w_slow = wr.en && wr.idx == SS_IDX_SLOW;
  wire logic w_clim = wr.en && wr.idx == SS_IDX_CLIM;
  wire logic w_tlim = wr.en && wr.idx == SS_IDX_TLIM;
  wire logic w_amp = wr.en && wr.idx == SS_IDX_AMP;
  wire logic w_brk = wr.en && wr.idx == SS_IDX_BRK;
  wire logic w_qs = wr.en && wr.idx == SS_IDX_QS;
  wire logic w_sd = wr.en && wr.idx == SS_IDX_SD;
  wire logic w_dis = wr.en && wr.idx == SS_IDX_DIS;
  wire logic w_qsdec = wr.en && wr.idx == SS_IDX_QSDEC;
  wire logic [15:0] m_inh = 16'(ss_merge({16'h0000, inh_sel_r}, wr.data,
                                         wr.strb));
  wire logic [15:0] m_qs = 16'(ss_merge({16'h0000, qs_sel_r}, wr.data,
                                        wr.strb));
  wire logic [15:0] m_sd = 16'(ss_merge({16'h0000, sd_sel_r}, wr.data,
                                        wr.strb));
  wire logic [15:0] m_dis = 16'(ss_merge({16'h0000, dis_sel_r}, wr.data,
                                         wr.strb));
  // Out-of-range codes are refused with an error, old value kept
  wire logic ok_inh = ss_code_ok(m_inh, 1'b0);
  wire logic ok_qs = ss_code_ok(m_qs, 1'b1);
  wire logic ok_sd = ss_code_ok(m_sd, 1'b0);
  wire logic ok_dis = ss_code_ok(m_dis, 1'b0);
  wire logic hit_w = w_inh | w_slow | w_clim | w_tlim | w_amp | w_brk |
                     w_qs | w_sd | w_dis | w_qsdec;
  wire logic bad_w = (w_inh && !ok_inh) || (w_qs && !ok_qs) ||
                     (w_sd && !ok_sd) || (w_dis && !ok_dis);
  // Address bits above the index are ignored, so aliases of a register
  // answer too; cheaper than a full compare on every access
  assign wr_ok = hit_w && !bad_w;

  // Stored only when legal; merging keeps untouched lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inh_sel_r <= SS_RST_INH;
      slow_ramp_r <= SS_RST_SLOW;
      clim_r <= SS_RST_CLIM;
      tlim_r <= SS_RST_TLIM;
      amp_r <= SS_RST_AMP;
      brk_r <= SS_RST_BRK;
      qs_sel_r <= SS_RST_QS;
      sd_sel_r <= SS_RST_SD;
      dis_sel_r <= SS_RST_DIS;
      qs_dec_r <= SS_RST_QSDEC;
    end else begin
      if (w_inh && ok_inh) inh_sel_r <= m_inh;
      if (w_slow) slow_ramp_r <= ss_merge(slow_ramp_r, wr.data, wr.strb);
      if (w_clim) clim_r <= 16'(ss_merge({16'h0000, clim_r}, wr.data,
                                         wr.strb));
      if (w_tlim) tlim_r <= wr_mrg[15:0] | (tlim_r & ~{{8{wr.strb[1]}},
                                                      {8{wr.strb[0]}}});
      if (w_amp) amp_r <= 16'(ss_merge({16'h0000, amp_r}, wr.data,
                                       wr.strb));
      if (w_brk) brk_r <= 16'(ss_merge({16'h0000, brk_r}, wr.data,
                                       wr.strb));
      if (w_qs && ok_qs) qs_sel_r <= m_qs;
      if (w_sd && ok_sd) sd_sel_r <= m_sd;
      if (w_dis && ok_dis) dis_sel_r <= m_dis;
      if (w_qsdec) qs_dec_r <= ss_merge(qs_dec_r, wr.data, wr.strb);
    end
  end

  // ==========================================================
  // Read decode; status word shows the sequencer's own state
  wire logic [15:0] rd_idx = araddr[SS_IDX_MSB:SS_IDX_LSB];
  // Status: [4:0] state, [6:5] kind, [7] hold, [8] enable, [9] inhibit,
  // [10] limit switch; read only, so a write to it answers with an error
  wire logic [31:0] stat_word = {21'h0, limit_sw, inhibit_phys_input,
                                 drive_en_r, hold_r, kind_r, state_r};
  always_comb begin
    rd_ok = 1'b1;
    case (rd_idx)
      SS_IDX_INH: rd_data = {16'h0000, inh_sel_r};
      SS_IDX_SLOW: rd_data = slow_ramp_r;
      SS_IDX_CLIM: rd_data = {16'h0000, clim_r};
      SS_IDX_TLIM: rd_data = {16'h0000, tlim_r};
      SS_IDX_AMP: rd_data = {16'h0000, amp_r};
      SS_IDX_BRK: rd_data = {16'h0000, brk_r};
      SS_IDX_QS: rd_data = {16'h0000, qs_sel_r};
      SS_IDX_SD: rd_data = {16'h0000, sd_sel_r};
      SS_IDX_DIS: rd_data = {16'h0000, dis_sel_r};
      SS_IDX_QSDEC: rd_data = qs_dec_r;
      SS_IDX_STAT: rd_data = stat_word;
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Trigger selection: each transition reads its own register
  ss_stop_t sel;
  logic trig;
  // Limit switch is a level: still high after a stop, it stops again
  always_comb begin
    trig = 1'b1;
    if (limit_sw) begin
      sel = '{kind: SS_KIND_SLOW, hold: 1'b0};
    end else if (qs_trans) begin
      sel = ss_decode(qs_sel_r);
    end else if (dis_trans) begin
      sel = ss_decode(dis_sel_r);
    end else if (sd_trans) begin
      sel = ss_decode(sd_sel_r);
    end else begin
      sel = '{kind: SS_KIND_NONE, hold: 1'b0};
      trig = 1'b0;
    end
  end

  // ==========================================================
  // Ramp arithmetic: setpoint magnitude shrinks by one step a cycle
  wire logic is_quick = kind_r == SS_KIND_QUICK;
  wire logic [31:0] decel = is_quick ? qs_dec_r
                                     : slow_ramp_r;
  wire logic sp_neg = speed_sp_r[31];
  wire logic [31:0] sp_abs = sp_neg ? 32'(-speed_sp_r) : speed_sp_r;
  wire logic sp_last = sp_abs <= decel;
  wire logic [31:0] sp_step = sp_neg ? 32'(speed_sp_r + decel)
                                     : 32'(speed_sp_r - decel);
  wire logic motor_still = motor_speed == 32'h0000_0000;
  wire logic ramp_done = motor_still && speed_sp_r == 32'h0000_0000;

  // ==========================================================
  // Sequencer state
  ss_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SS_ST_OFF: begin
        if (enable_cmd) state_nxt = SS_ST_RUN;
      end
      SS_ST_RUN, SS_ST_HOLD: begin
        if (trig) begin
          case (sel.kind)
            SS_KIND_SLOW, SS_KIND_QUICK: state_nxt = SS_ST_RAMP;
            SS_KIND_CLIM: state_nxt = SS_ST_CLAMP;
            default: state_nxt = SS_ST_OFF;
          endcase
        end else if (enable_cmd && state_r == SS_ST_HOLD) begin
          state_nxt = SS_ST_RUN;
        end
      end
      SS_ST_RAMP: begin
        if (ramp_done) state_nxt = hold_r ? SS_ST_HOLD : SS_ST_OFF;
      end
      SS_ST_CLAMP: begin
        // No setpoint here: besides inhibit, only the measured speed can end the clamp
        if (motor_still) begin
          state_nxt = hold_r ? SS_ST_HOLD : SS_ST_OFF;
        end
      end
      default: state_nxt = SS_ST_OFF;
    endcase
    // Inhibit overrides everything, option code not consulted
    if (inhibit_phys_input) state_nxt = SS_ST_OFF;
  end

  // A stop starts only from run or hold, and never against inhibit
  wire logic start_stop = (state_r == SS_ST_RUN || state_r == SS_ST_HOLD) &&
                          trig && sel.kind != SS_KIND_NONE &&
                          !inhibit_phys_input;

  // State, stop kind and follow-on choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SS_ST_OFF;
      kind_r <= SS_KIND_NONE;
      hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_stop) begin
        kind_r <= sel.kind;
        hold_r <= sel.hold;
      end else if (state_nxt == SS_ST_RUN || state_nxt == SS_ST_OFF) begin
        kind_r <= SS_KIND_NONE;
      end
    end
  end

  // ==========================================================
  // Loop, setpoint and current clamp outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_sel_r <= SS_LOOP_POS;
      speed_sp_r <= 32'h0000_0000;
      cur_clamp_r <= 1'b0;
      cur_limit_r <= SS_RST_CLIM;
    end else if (start_stop) begin
      case (sel.kind)
        SS_KIND_SLOW: begin
          loop_sel_r <= SS_LOOP_POS;
          speed_sp_r <= ref_speed;
        end
        SS_KIND_QUICK: begin
          loop_sel_r <= SS_LOOP_SPEED;
          speed_sp_r <= motor_speed;
        end
        default: begin
          loop_sel_r <= SS_LOOP_VEL;
          speed_sp_r <= 32'h0000_0000;
          cur_clamp_r <= 1'b1;
          cur_limit_r <= clim_r;
        end
      endcase
    end else if (state_r == SS_ST_RAMP) begin
      // Saturate at zero so the last step never overshoots
      speed_sp_r <= sp_last ? 32'h0000_0000 : sp_step;
    end else if (state_r != SS_ST_CLAMP) begin
      cur_clamp_r <= 1'b0;
      speed_sp_r <= 32'h0000_0000;
    end
  end

  // Drive enable, quick-stop hold and activity flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_en_r <= 1'b0;
      quick_stop_r <= 1'b0;
      stop_active_r <= 1'b0;
    end else begin
      drive_en_r <= state_nxt != SS_ST_OFF;
      quick_stop_r <= state_nxt == SS_ST_HOLD;
      stop_active_r <= state_nxt == SS_ST_RAMP || state_nxt == SS_ST_CLAMP;
    end
  end

endmodule : ss_stop_seq
`default_nettype wire

/* core/ss_pkg.sv */
// Shared constants, types and decode functions of the stop sequencer.
// Assumes a 32-bit AXI4-Lite register bus, one word per register index.
package ss_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] SS_IDX_INH = 16'h305A;
  localparam logic [15:0] SS_IDX_SLOW = 16'h3300;
  localparam logic [15:0] SS_IDX_CLIM = 16'h3301;
  localparam logic [15:0] SS_IDX_TLIM = 16'h3302;
  localparam logic [15:0] SS_IDX_AMP = 16'h3304;
  localparam logic [15:0] SS_IDX_BRK = 16'h3305;
  localparam logic [15:0] SS_IDX_STAT = 16'h3310;
  localparam logic [15:0] SS_IDX_QS = 16'h605A;
  localparam logic [15:0] SS_IDX_SD = 16'h605B;
  localparam logic [15:0] SS_IDX_DIS = 16'h605C;
  localparam logic [15:0] SS_IDX_QSDEC = 16'h6085;
  localparam int SS_IDX_LSB = 2;
  localparam int SS_IDX_MSB = 17;

  // ==========================================================
  // Reset values
  localparam logic [15:0] SS_RST_INH = 16'h0001;
  localparam logic [31:0] SS_RST_SLOW = 32'h0000_0000;
  localparam logic [15:0] SS_RST_CLIM = 16'h03E8;
  localparam logic [15:0] SS_RST_TLIM = 16'h03E8;
  localparam logic [15:0] SS_RST_AMP = 16'h0000;
  localparam logic [15:0] SS_RST_BRK = 16'h0000;
  localparam logic [15:0] SS_RST_QS = 16'h0001;
  localparam logic [15:0] SS_RST_SD = 16'h0000;
  localparam logic [15:0] SS_RST_DIS = 16'h0001;
  localparam logic [31:0] SS_RST_QSDEC = 32'h0020_0000;

  // ==========================================================
  // Stop kinds, loops, states and AXI responses
  typedef enum logic [1:0] {
    SS_KIND_NONE = 2'h0,
    SS_KIND_SLOW = 2'h1,
    SS_KIND_QUICK = 2'h2,
    SS_KIND_CLIM = 2'h3
  } ss_kind_t;

  typedef enum logic [1:0] {
    SS_LOOP_POS = 2'h0,
    SS_LOOP_SPEED = 2'h1,
    SS_LOOP_VEL = 2'h2
  } ss_loop_t;

  typedef enum logic [4:0] {
    SS_ST_OFF = 5'h01,
    SS_ST_RUN = 5'h02,
    SS_ST_RAMP = 5'h04,
    SS_ST_CLAMP = 5'h08,
    SS_ST_HOLD = 5'h10
  } ss_state_t;

  localparam logic [1:0] SS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SS_RESP_SLVERR = 2'h2;
  localparam logic [2:0] SS_HOLD_BIT = 3'h4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic en;
    logic [15:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } ss_wr_t;

  typedef struct packed {
    ss_kind_t kind;
    logic hold;
  } ss_stop_t;

  // Option code to stop kind; bit 2 with a nonzero kind (codes 5..7) selects staying in quick-stop
  function automatic ss_stop_t ss_decode(input logic [15:0] code);
    ss_stop_t s;
    s.kind = ss_kind_t'(code[1:0]);
    s.hold = (code[2:0] > SS_HOLD_BIT) && (code[15:3] == 13'h0000);
    if (code[15:2] != 14'h0000 && !s.hold) begin
      s.kind = SS_KIND_NONE;
    end
    return s;
  endfunction : ss_decode

  // Legal codes: 0..3 always, 5..7 only where quick-stop hold exists
  function automatic logic ss_code_ok(input logic [15:0] code,
                                      input logic with_hold);
    return (code[15:2] == 14'h0000) ||
           (with_hold && code[15:3] == 13'h0000 && code[2:0] > SS_HOLD_BIT);
  endfunction : ss_code_ok

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] ss_merge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction : ss_merge

endpackage : ss_pkg

/* core/ss_axil_slave.sv */
// AXI4-Lite slave front end of the stop sequencer.
// Assumes the parent decodes the write and read index in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module ss_axil_slave
  import ss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output ss_wr_t wr,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  // ==========================================================
  // Write path
  logic aw_full_r;
  logic w_full_r;
  logic [15:0] aw_idx_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic wr_go;

  // Both halves held and no answer pending: commit exactly once
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign wr = '{en: wr_go, idx: aw_idx_r, data: w_data_r, strb: w_strb_r};
  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // Address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= 16'h0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= SS_RESP_OKAY;
    end else begin
      if (awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_idx_r <= awaddr[SS_IDX_MSB:SS_IDX_LSB];
      end
      if (wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? SS_RESP_OKAY : SS_RESP_SLVERR;
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path: data sampled at the address handshake
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= SS_RESP_OKAY;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_ok ? rd_data : 32'h0000_0000;
      rresp_r <= rd_ok ? SS_RESP_OKAY : SS_RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : ss_axil_slave
`default_nettype wire

/* test/ss_master_model.sv */
// Fieldbus master model: issues drive state machine commands.
// Assumes the bench asks for one command at a time through go and sel.
`timescale 1ns/1ps
`default_nettype none
module ss_master_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [1:0] sel,
  output logic enable_cmd,
  output logic qs_trans,
  output logic dis_trans,
  output logic sd_trans
);
  // ==========
  // Commands
  // Transitions are events, so each is a one-cycle pulse
  always_ff @(posedge aclk) begin
    enable_cmd <= aresetn && go && sel == 2'h0;
    qs_trans <= aresetn && go && sel == 2'h1;
    dis_trans <= aresetn && go && sel == 2'h2;
    sd_trans <= aresetn && go && sel == 2'h3;
  end
endmodule : ss_master_model
`default_nettype wire

/* test/ss_stop_seq_chk.sv */
// Checker of the stop sequencer top ports.
// Assumes one clock domain and positive motor and reference speeds.
`timescale 1ns/1ps
`default_nettype none
module ss_stop_seq_chk
  import ss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inhibit_phys_input,
  input wire logic [31:0] ref_speed,
  input wire logic [31:0] motor_speed,
  input wire logic drive_en_r,
  input wire logic quick_stop_r,
  input wire logic stop_active_r,
  input wire ss_loop_t loop_sel_r,
  input wire logic [31:0] speed_sp_r,
  input wire logic cur_clamp_r,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  // ==========
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_inhibit_off: assert property (inhibit_phys_input |=>
    !drive_en_r && !stop_active_r) else $error("inhibit kept drive on");
  chk_slow_start: assert property ($rose(stop_active_r) &&
    loop_sel_r == SS_LOOP_POS |-> speed_sp_r == $past(ref_speed))
    else $error("slow ramp start wrong");
  chk_quick_start: assert property ($rose(stop_active_r) &&
    loop_sel_r == SS_LOOP_SPEED |-> speed_sp_r == $past(motor_speed))
    else $error("quick ramp start wrong");
  chk_clamp_loop: assert property (stop_active_r && cur_clamp_r |->
    loop_sel_r == SS_LOOP_VEL) else $error("clamp not in velocity loop");
  chk_stop_enabled: assert property (stop_active_r |-> drive_en_r)
    else $error("stop with drive off");
  chk_stop_end: assert property (stop_active_r &&
    motor_speed == 32'h0 && speed_sp_r == 32'h0 |=> !stop_active_r)
    else $error("stop not ended");
  chk_no_early: assert property (stop_active_r &&
    motor_speed != 32'h0 && !inhibit_phys_input |=> stop_active_r)
    else $error("stop ended early");
  chk_hold_state: assert property (quick_stop_r |->
    drive_en_r && !stop_active_r) else $error("bad quick-stop hold");
  chk_bresp_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read answer dropped");
endmodule : ss_stop_seq_chk
bind ss_stop_seq ss_stop_seq_chk i_ss_stop_seq_chk (.*);
`default_nettype wire

/* test/ss_stop_seq_bench.sv */
// Self-checking bench of the stop sequencer.
// Assumes the master model drives transitions; bench drives AXI and speeds.
`timescale 1ns/1ps
`default_nettype none
module ss_stop_seq_bench
  import ss_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic awready, wready, bvalid, arready, rvalid, limit_sw;
  logic [31:0] awaddr, wdata, araddr, rdata, ref_speed, motor_speed;
  logic [31:0] speed_sp_r, ds, dq, lim, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sel, r;
  logic enable_cmd, qs_trans, dis_trans, sd_trans, inhibit_phys_input;
  logic drive_en_r, quick_stop_r, stop_active_r, cur_clamp_r;
  ss_loop_t loop_sel_r;
  logic [15:0] cur_limit_r;
  int num_errors, n_checks;
  localparam logic [15:0] IDX [10] = '{SS_IDX_INH, SS_IDX_SLOW, SS_IDX_CLIM,
    SS_IDX_TLIM, SS_IDX_AMP, SS_IDX_BRK, SS_IDX_QS, SS_IDX_SD, SS_IDX_DIS,
    SS_IDX_QSDEC};
  localparam logic [31:0] RST [10] = '{{16'h0, SS_RST_INH}, SS_RST_SLOW,
    {16'h0, SS_RST_CLIM}, {16'h0, SS_RST_TLIM}, {16'h0, SS_RST_AMP},
    {16'h0, SS_RST_BRK}, {16'h0, SS_RST_QS}, {16'h0, SS_RST_SD},
    {16'h0, SS_RST_DIS}, SS_RST_QSDEC};
  localparam logic [15:0] QCODES [7] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h5,
    16'h6, 16'h7};

  // ==========
  // Clock and parts
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ss_stop_seq i_ss_stop_seq (.*);
  ss_master_model i_ss_master_model (.*);

  // ==========
  // Tasks
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A wait that ran out ends the run at once, nothing later is trusted
  task automatic tmo(input int n);
    if (n >= 60) begin
      num_errors++;
      $display("[ERR] %0t wait timed out", $time);
      close_out();
    end
  endtask : tmo
  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= {14'h0, idx, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(n);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] idx);
    int n;
    @(posedge aclk);
    araddr <= {14'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Command through the master model; returns just after the design acts
  task automatic cmd(input logic [1:0] s);
    @(posedge aclk);
    go <= 1'b1;
    sel <= s;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : cmd
  // Trigger t: 1 quick stop, 2 disable, 3 shutdown, 4 limit switch
  task automatic do_stop(input int t, input logic [15:0] c);
    logic [31:0] s0, dec;
    logic [1:0] k;
    int n;
    k = (t == 4) ? 2'h1 : c[1:0];
    dec = (k == 2'h2) ? dq : ds;
    s0 = dec * $urandom_range(2, 5);
    cmd(2'h0);
    ref_speed <= (k == 2'h1) ? s0 : s0 + 32'h9;
    motor_speed <= (k == 2'h1) ? s0 + 32'h9 : s0;
    if (t == 4) begin
      @(posedge aclk);
      limit_sw <= 1'b1;
      @(posedge aclk);
      #1;
    end else
      cmd(t[1:0]);
    chk(drive_en_r, k != 2'h0);
    chk(stop_active_r, k != 2'h0);
    if (k != 2'h0) begin
      chk(loop_sel_r, k - 1);
      if (k == 2'h3)
        chk({cur_clamp_r, cur_limit_r}, {1'b1, lim[15:0]});
      else begin
        chk(speed_sp_r, s0);
        @(posedge aclk);
        #1;
        chk(speed_sp_r, s0 - dec);
      end
      @(posedge aclk);
      limit_sw <= 1'b0;
      motor_speed <= 32'h0;
      for (n = 0; n < 60; n++) begin
        @(posedge aclk);
        #1;
        if (!stop_active_r) break;
      end
      tmo(n);
      chk(quick_stop_r, c[2]);
      chk(drive_en_r, c[2]);
    end
  endtask : do_stop

  // ==========
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go, limit_sw} = '0;
    {aresetn, inhibit_phys_input, sel, awaddr, wdata, araddr} = '0;
    {ref_speed, motor_speed} = '0;
    wstrb = 4'hF;
    num_errors = 0;
    n_checks = 0;
    void'($urandom(32'hD202A660));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (IDX[i]) begin
      rd(IDX[i]);
      chk(d, RST[i]);
    end
    rd(SS_IDX_STAT);
    chk(d, 32'h1); // Status shows the off state alone
    rd(16'h1000);
    chk(r, SS_RESP_SLVERR);
    chk(d, 32'h0);
    ds = $urandom_range(1, 200);
    dq = $urandom_range(1, 200);
    lim = $urandom_range(100, 6000);
    wr(SS_IDX_SLOW, ds);
    wr(SS_IDX_QSDEC, dq);
    wr(SS_IDX_CLIM, lim);
    foreach (QCODES[i]) begin
      wr(SS_IDX_QS, QCODES[i]);
      do_stop(1, QCODES[i]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(SS_IDX_DIS, c);
      do_stop(2, c);
      wr(SS_IDX_SD, c);
      do_stop(3, c);
    end
    // Out-of-range codes are refused and the old value stays
    wr(SS_IDX_SD, 32'h5);
    chk(r, SS_RESP_SLVERR);
    rd(SS_IDX_SD);
    chk(r, SS_RESP_OKAY);
    chk(d, 32'h3);
    wr(SS_IDX_QS, 32'h4);
    chk(r, SS_RESP_SLVERR);
    do_stop(4, 16'h0);
    // Inhibit in mid-ramp, whatever its own code selects
    wr(SS_IDX_INH, 32'h3);
    wr(SS_IDX_QS, 32'h6);
    motor_speed <= 32'h1000;
    cmd(2'h0);
    cmd(2'h1);
    @(posedge aclk);
    inhibit_phys_input <= 1'b1;
    @(posedge aclk);
    #1;
    chk({drive_en_r, stop_active_r}, 32'h0);
    inhibit_phys_input <= 1'b0;
    close_out();
  end
endmodule : ss_stop_seq_bench
`default_nettype wire
